// [src/gpt_timer.sv]
// General purpose timer: prescaler, auto-reload counter, channels, status and interrupt.
// Assumes one 100 MHz clock, synchronous inputs, a master that never waits.
//
// What this block does
// - The standard build has a 16-bit auto-reload counter counting up, down or up/down.
// - A wide build uses a 32-bit counter with the same three counting choices.
// - A 16-bit prescaler makes the counter step once every (programmed value + 1) ticks.
// - The full build has four channels for capture, compare, PWM or one-pulse output.
// - Every build with channels can drive PWM on its channel outputs.
// - Sync inputs and trigger outputs let several timers run together for one clock or chain events.
// - With freeze selected, the counter holds while the debug halt input is high.
// - The full and wide builds raise their own DMA requests.
// - Encoder mode counts up or down from the phase of two quadrature inputs.
// - One to three hall sensor outputs on the channel inputs act as timing inputs.
// - A one-channel build counts up only on a 16-bit counter with one channel.
// - A two-channel build keeps the 16-bit up/down counter with two channels.
// - Reduced builds may count on the low-speed external clock edges.
// - A build with no channels is a 16-bit up time base whose update triggers a converter.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module gpt_timer #(
	parameter int W = 16,
	parameter int NCH = 4,
	parameter bit UPDOWN = 1'b1,
	parameter bit HAS_DMA = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire gpt_pkg::gpt_bus_req_t bus,
	output logic [31:0] rdata,
	output logic irq,
	input wire logic dbg_halt,
	input wire logic slow_tick,
	input wire logic sync_in,
	output logic trig_out,
	output logic adc_trig,
	output logic dma_req,
	input wire logic [3:0] ch_in,
	output logic [3:0] ch_out
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [15:0] psc_r, psc_nxt;
	logic [W-1:0] arr_r, arr_nxt;
	logic [gpt_pkg::STAT_W-1:0] stat_r, stat_nxt;
	logic [gpt_pkg::STAT_W-1:0] mask_r, mask_nxt;
	logic [7:0] ccmode_r, ccmode_nxt;
	logic [W-1:0] ccr_r [4];
	logic [W-1:0] ccr_nxt [4];
	logic [31:0] rdata_r, rdata_nxt;

	// Counter state
	logic [W-1:0] cnt_r, cnt_nxt;
	logic [15:0] pre_r, pre_nxt;
	logic down_r, down_nxt;
	logic [1:0] qa_r, qa_nxt;
	logic [2:0] hall_r, hall_nxt;
	logic sync_r, sync_nxt;

	logic [3:0] ch_evt;
	logic [W-1:0] cap_val [4];
	logic upd, tick, src_tick, run, enc_step, enc_dir, hall_evt, sync_rise;
	logic [gpt_pkg::STAT_W-1:0] evts;
	gpt_pkg::gpt_dir_t dir;
	gpt_pkg::gpt_cnt_t cv;

	// Address match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Direction allowed by the build
	always_comb begin
		if (!UPDOWN || NCH == 1 || NCH == 0) begin
			dir = gpt_pkg::GPT_DIR_UP;
		end else begin
			dir = gpt_pkg::gpt_dir_t'(ctrl_r[gpt_pkg::CTRL_DIR_LO +: 2]);
		end
	end

	// ----------------------------------------
	// Prescaler, encoder, hall and counter
	// ----------------------------------------
	always_comb begin
		qa_nxt = ch_in[1:0];
		hall_nxt = ch_in[2:0];
		sync_nxt = sync_in;
		sync_rise = sync_in && !sync_r;
		// Quadrature: step on either edge of input A, sign from B
		enc_step = (ch_in[0] != qa_r[0]);
		enc_dir = (ch_in[0] == ch_in[1]);
		hall_evt = ctrl_r[gpt_pkg::CTRL_HALL] && (ch_in[2:0] != hall_r);
		// Slave mode: a rising sync runs the counter for that one clock only
		run = ctrl_r[gpt_pkg::CTRL_EN] || (ctrl_r[gpt_pkg::CTRL_SLAVE] && sync_rise);
		if (ctrl_r[gpt_pkg::CTRL_FRZ] && dbg_halt) begin
			run = 1'b0;
		end
		src_tick = ctrl_r[gpt_pkg::CTRL_CLKSEL] ? slow_tick : 1'b1;
		pre_nxt = pre_r;
		tick = 1'b0;
		if (run && ctrl_r[gpt_pkg::CTRL_ENC]) begin
			tick = enc_step;
			pre_nxt = '0;
		end else if (run && src_tick) begin
			if (pre_r >= psc_r) begin
				pre_nxt = '0;
				tick = 1'b1;
			end else begin
				pre_nxt = pre_r + 16'h0001;
			end
		end
		cnt_nxt = cnt_r;
		down_nxt = down_r;
		upd = 1'b0;
		if (tick) begin
			if (ctrl_r[gpt_pkg::CTRL_ENC]) begin
				cnt_nxt = enc_dir ? ((cnt_r == arr_r) ? '0 : cnt_r + 1'b1)
					: ((cnt_r == '0) ? arr_r : cnt_r - 1'b1);
			end else if (dir == gpt_pkg::GPT_DIR_UP) begin
				if (cnt_r >= arr_r) begin
					cnt_nxt = '0;
					upd = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end else if (dir == gpt_pkg::GPT_DIR_DOWN) begin
				if (cnt_r == '0) begin
					cnt_nxt = arr_r;
					upd = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end else begin
				// Up/down: turn at the ends, update at each turn
				if (!down_r && cnt_r >= arr_r) begin
					down_nxt = 1'b1;
					cnt_nxt = (arr_r == '0) ? '0 : cnt_r - 1'b1;
					upd = 1'b1;
				end else if (down_r && cnt_r == '0) begin
					down_nxt = 1'b0;
					cnt_nxt = cnt_r + 1'b1;
					upd = 1'b1;
				end else begin
					cnt_nxt = down_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
				end
			end
		end
	end

	// Counter registers
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
			pre_r <= '0;
			down_r <= 1'b0;
			qa_r <= 2'h0;
			hall_r <= 3'h0;
			sync_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			pre_r <= pre_nxt;
			down_r <= down_nxt;
			qa_r <= qa_nxt;
			hall_r <= hall_nxt;
			sync_r <= sync_nxt;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	assign cv.cnt = 32'(cnt_r);
	assign cv.tick = tick;
	assign cv.upd = upd;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			if (g < NCH) begin : g_on
				gpt_channel #(.W(W)) u_ch (
					.clk(clk),
					.srst(srst),
					.cv(cv),
					.mode(gpt_pkg::gpt_ch_mode_t'(ccmode_r[2*g +: 2])),
					.ccr(ccr_r[g]),
					.cap_in(ch_in[g]),
					.ch_out(ch_out[g]),
					.cap_val(cap_val[g]),
					.ch_evt(ch_evt[g])
				);
			end else begin : g_off
				assign ch_out[g] = 1'b0;
				assign cap_val[g] = '0;
				assign ch_evt[g] = 1'b0;
			end
		end
	endgenerate

	// Trigger, converter trigger and DMA outputs
	assign trig_out = upd;
	assign adc_trig = upd;
	assign dma_req = HAS_DMA && ctrl_r[gpt_pkg::CTRL_DMAEN] && (upd || (|ch_evt));
	assign evts = {sync_rise || hall_evt, ch_evt, upd};
	assign irq = |(stat_r & mask_r);
	assign rdata = rdata_r;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		psc_nxt = psc_r;
		arr_nxt = arr_r;
		mask_nxt = mask_r;
		ccmode_nxt = ccmode_r;
		ccr_nxt = ccr_r;
		rdata_nxt = 32'h0000_0000;
		stat_nxt = stat_r;
		if (bus.wr) begin
			if (hit(bus.addr, gpt_pkg::GPT_CTRL)) ctrl_nxt = bus.wdata;
			if (hit(bus.addr, gpt_pkg::GPT_PSC)) psc_nxt = bus.wdata[15:0];
			if (hit(bus.addr, gpt_pkg::GPT_ARR)) arr_nxt = bus.wdata[W-1:0];
			if (hit(bus.addr, gpt_pkg::GPT_MASK)) mask_nxt = bus.wdata[gpt_pkg::STAT_W-1:0];
			if (hit(bus.addr, gpt_pkg::GPT_CCMODE)) ccmode_nxt = bus.wdata[7:0];
			for (int i = 0; i < 4; i++) begin
				if (hit(bus.addr, gpt_pkg::GPT_CC0 + 8'(4 * i))) ccr_nxt[i] = bus.wdata[W-1:0];
			end
		end
		if (bus.rd) begin
			case (bus.addr)
				gpt_pkg::GPT_CTRL: rdata_nxt = ctrl_r;
				gpt_pkg::GPT_PSC: rdata_nxt = 32'(psc_r);
				gpt_pkg::GPT_ARR: rdata_nxt = 32'(arr_r);
				gpt_pkg::GPT_CNT: rdata_nxt = 32'(cnt_r);
				gpt_pkg::GPT_STAT: rdata_nxt = 32'(stat_r);
				gpt_pkg::GPT_MASK: rdata_nxt = 32'(mask_r);
				gpt_pkg::GPT_CCMODE: rdata_nxt = 32'(ccmode_r);
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (hit(bus.addr, gpt_pkg::GPT_CC0 + 8'(4 * i))) begin
							rdata_nxt = ccmode_r[2*i +: 2] == gpt_pkg::GPT_CH_CAP
								? 32'(cap_val[i]) : 32'(ccr_r[i]);
						end
					end
				end
			endcase
			if (hit(bus.addr, gpt_pkg::GPT_STAT)) stat_nxt = '0;
		end
		// Set wins over the read clear
		stat_nxt = stat_nxt | evts;
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= gpt_pkg::RST_CTRL;
			psc_r <= gpt_pkg::RST_PSC;
			arr_r <= gpt_pkg::RST_ARR[W-1:0];
			stat_r <= '0;
			mask_r <= '0;
			ccmode_r <= 8'h00;
			ccr_r <= '{default: '0};
			rdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			psc_r <= psc_nxt;
			arr_r <= arr_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			ccmode_r <= ccmode_nxt;
			ccr_r <= ccr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_upd_reload: assert property (@(posedge clk) disable iff (srst)
		upd && dir == gpt_pkg::GPT_DIR_UP && !ctrl_r[gpt_pkg::CTRL_ENC] |=> cnt_r == '0)
		else $error("update did not reload counter");
	a_freeze_hold: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[gpt_pkg::CTRL_FRZ] && dbg_halt |=> cnt_r == $past(cnt_r))
		else $error("counter moved while frozen");
	a_psc_step: assert property (@(posedge clk) disable iff (srst)
		tick && !ctrl_r[gpt_pkg::CTRL_ENC] |-> pre_r >= psc_r)
		else $error("tick before prescaler expired");
	a_cnt_bound: assert property (@(posedge clk) disable iff (srst)
		$past(bus.wr) == 1'b0 && !ctrl_r[gpt_pkg::CTRL_ENC] && tick && !down_r
		&& dir != gpt_pkg::GPT_DIR_DOWN && cnt_r < arr_r |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("counter did not step up");
	a_trig_upd: assert property (@(posedge clk) disable iff (srst)
		trig_out == upd && adc_trig == upd)
		else $error("trigger not tied to update");
	a_stat_sticky: assert property (@(posedge clk) disable iff (srst)
		upd |=> stat_r[gpt_pkg::STAT_UPD])
		else $error("update flag lost");
	a_irq_level: assert property (@(posedge clk) disable iff (srst)
		irq == |(stat_r & mask_r))
		else $error("interrupt level wrong");
	a_stat_clear: assert property (@(posedge clk) disable iff (srst)
		bus.rd && hit(bus.addr, gpt_pkg::GPT_STAT) && evts == '0 |=> stat_r == '0)
		else $error("status not cleared by read");
	a_dma_off: assert property (@(posedge clk) disable iff (srst)
		!ctrl_r[gpt_pkg::CTRL_DMAEN] |-> !dma_req)
		else $error("dma request while disabled");

endmodule // gpt_timer

// [src/gpt_pkg.sv]
// Package for the general purpose timer: register map, fields, reset values, modes.
// Assumes a single 100 MHz clock domain and a plain address/strobe register port.
package gpt_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] GPT_CTRL = 8'h00;
	localparam logic [7:0] GPT_PSC = 8'h04;
	localparam logic [7:0] GPT_ARR = 8'h08;
	localparam logic [7:0] GPT_CNT = 8'h0c;
	localparam logic [7:0] GPT_STAT = 8'h10;
	localparam logic [7:0] GPT_MASK = 8'h14;
	localparam logic [7:0] GPT_CCMODE = 8'h18;
	localparam logic [7:0] GPT_CC0 = 8'h20;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int CTRL_EN = 0;
	localparam int CTRL_DIR_LO = 1;
	localparam int CTRL_FRZ = 3;
	localparam int CTRL_OPM = 4;
	localparam int CTRL_CLKSEL = 5;
	localparam int CTRL_ENC = 6;
	localparam int CTRL_HALL = 7;
	localparam int CTRL_SLAVE = 8;
	localparam int CTRL_DMAEN = 9;

	// Status bits: 0 update, 1..4 channel events, 5 trigger in
	localparam int STAT_UPD = 0;
	localparam int STAT_CC0 = 1;
	localparam int STAT_TRG = 5;
	localparam int STAT_W = 6;

	// Reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_ARR = 32'h0000_ffff;
	localparam logic [15:0] RST_PSC = 16'h0000;

	// Low speed edge detector: 32.768 kHz is an event source, sampled
	localparam real SLOW_CLK_HZ = 32768.0;

	// Counting direction modes
	typedef enum logic [1:0] {
		GPT_DIR_UP = 2'h0,
		GPT_DIR_DOWN = 2'h1,
		GPT_DIR_CENTER = 2'h2
	} gpt_dir_t;

	// Channel modes: 0 capture, 1 compare toggle, 2 pwm, 3 one-pulse
	typedef enum logic [1:0] {
		GPT_CH_CAP = 2'h0,
		GPT_CH_CMP = 2'h1,
		GPT_CH_PWM = 2'h2,
		GPT_CH_OPM = 2'h3
	} gpt_ch_mode_t;

	// Register port carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} gpt_bus_req_t;

	// Counter state offered to each channel
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
		logic upd;
	} gpt_cnt_t;

endpackage

// [src/gpt_channel.sv]
// One capture/compare channel of the general purpose timer.
// Assumes the counter view arrives from the timer core on the same clock.
`timescale 1ns/100ps
module gpt_channel #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire gpt_pkg::gpt_cnt_t cv,
	input wire gpt_pkg::gpt_ch_mode_t mode,
	input wire logic [W-1:0] ccr,
	input wire logic cap_in,
	output logic ch_out,
	output logic [W-1:0] cap_val,
	output logic ch_evt
);

	// ----------------------------------------
	// Capture edge detect and compare output
	// ----------------------------------------
	logic in_r, in_nxt;
	logic out_r, out_nxt;
	logic [W-1:0] cap_r, cap_nxt;
	logic evt;
	logic hit;

	// Next values
	always_comb begin
		hit = cv.tick && (cv.cnt[W-1:0] == ccr);
		in_nxt = cap_in;
		cap_nxt = cap_r;
		out_nxt = out_r;
		evt = 1'b0;
		case (mode)
			gpt_pkg::GPT_CH_CAP: begin
				if (cap_in && !in_r) begin
					cap_nxt = cv.cnt[W-1:0];
					evt = 1'b1;
				end
			end
			gpt_pkg::GPT_CH_CMP: begin
				if (hit) begin
					out_nxt = !out_r;
					evt = 1'b1;
				end
			end
			gpt_pkg::GPT_CH_PWM: begin
				out_nxt = (cv.cnt[W-1:0] < ccr);
				evt = hit;
			end
			gpt_pkg::GPT_CH_OPM: begin
				if (cv.upd) begin
					out_nxt = 1'b0;
				end else if (hit) begin
					out_nxt = 1'b1;
					evt = 1'b1;
				end
			end
			default: begin
				out_nxt = 1'b0;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			in_r <= 1'b0;
			out_r <= 1'b0;
			cap_r <= '0;
		end else begin
			in_r <= in_nxt;
			out_r <= out_nxt;
			cap_r <= cap_nxt;
		end
	end

	assign ch_out = out_r;
	assign cap_val = cap_r;
	assign ch_evt = evt;

endmodule // gpt_channel

// [dv/gpt_far_model.sv]
// Far side of the timer: a quadrature encoder and a load on channel output 0.
// Assumes the bench pulses step for one clock and holds fwd beside it.
`timescale 1ns/100ps
module gpt_far_model (
	input wire logic clk,
	input wire logic step,
	input wire logic fwd,
	input wire logic load_in,
	input wire logic clr,
	output logic enc_a,
	output logic enc_b,
	output logic [15:0] high_cnt
);
	logic [1:0] pos_r = 2'h0;

	// Gray phase: B leads A going forward, A leads B going back
	always @(posedge clk) begin
		if (step) begin
			pos_r <= fwd ? pos_r + 2'h1 : pos_r - 2'h1;
		end
		high_cnt <= clr ? 16'h0 : high_cnt + {15'h0, load_in};
	end
	assign enc_a = pos_r[1];
	assign enc_b = pos_r[1] ^ pos_r[0];
endmodule // gpt_far_model

// [dv/test_gpt_timer.sv]
// Testbench for the general purpose timer: registers, counting, freeze, irq, encoder, pwm.
// Assumes a 100 MHz clock and the register map of the timer package.
`timescale 1ns/100ps
module test_gpt_timer;
	logic clk = 1'b0;
	logic srst = 1'b1;
	gpt_pkg::gpt_bus_req_t bus = '0;
	logic [31:0] rdata, rv, base;
	logic irq, trig_out, adc_trig, dma_req;
	logic dbg_halt = 1'b0, slow_tick = 1'b0, sync_in = 1'b0, slow_on = 1'b0, hall = 1'b0;
	logic step = 1'b0, fwd = 1'b1, clr = 1'b1, enc_a, enc_b;
	logic [2:0] slow_div = 3'h0;
	logic [3:0] ch_out;
	logic [15:0] high_cnt;
	int miscompares = 0;
	int n_checks = 0;
	int n;

	// ----------------------------------------
	// Clock, low-speed ticks, design and far side
	// ----------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk) begin
		slow_div <= slow_div + 3'h1;
		slow_tick <= slow_on && (slow_div == 3'h7);
	end
	gpt_timer i_gpt_timer (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .irq(irq),
		.dbg_halt(dbg_halt), .slow_tick(slow_tick), .sync_in(sync_in), .trig_out(trig_out),
		.adc_trig(adc_trig), .dma_req(dma_req), .ch_in({1'b0, hall, enc_b, enc_a}),
		.ch_out(ch_out));
	gpt_far_model i_gpt_far_model (.clk(clk), .step(step), .fwd(fwd), .load_in(ch_out[0]),
		.clr(clr), .enc_a(enc_a), .enc_b(enc_b), .high_cnt(high_cnt));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Waits, bounded, until an update pulse is seen
	task automatic sync_trig;
		int k;
		k = 0;
		#1;
		while (trig_out !== 1'b1 && k < 3000) begin
			@(posedge clk);
			#1 k++;
		end
		chk("update seen", {31'h0, trig_out}, 32'h1);
	endtask
	task automatic period(input string what, input int exp);
		int k;
		sync_trig();
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while (trig_out !== 1'b1 && k < 3000);
		chk(what, k, exp);
	endtask
	task automatic count_trig(input int cyc, output int c);
		c = 0;
		repeat (2) @(posedge clk);
		repeat (cyc) begin
			@(posedge clk);
			#1 c += (trig_out === 1'b1);
		end
	endtask
	task automatic steps(input int k, input logic f);
		repeat (k) begin
			@(posedge clk);
			step <= 1'b1;
			fwd <= f;
			@(posedge clk);
			step <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(gpt_pkg::GPT_CTRL, rv);
		chk("ctrl", rv, gpt_pkg::RST_CTRL);
		rd(gpt_pkg::GPT_ARR, rv);
		chk("arr", rv, gpt_pkg::RST_ARR);
		rd(gpt_pkg::GPT_PSC, rv);
		chk("psc", rv, {16'h0, gpt_pkg::RST_PSC});
		wr(8'h3c, 32'h1234);
		rd(8'h3c, rv);
		chk("unmapped", rv, 32'h0);
		chk("ch_out", {28'h0, ch_out}, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_count;
		wr(gpt_pkg::GPT_PSC, 32'h0);
		wr(gpt_pkg::GPT_ARR, 32'h2);
		wr(gpt_pkg::GPT_CTRL, 32'h1);
		period("up period", 3);
		wr(gpt_pkg::GPT_PSC, 32'h3);
		wr(gpt_pkg::GPT_ARR, 32'h4);
		period("prescaled period", 20);
		wr(gpt_pkg::GPT_PSC, 32'h1);
		wr(gpt_pkg::GPT_CTRL, 32'h3 | (32'h1 << gpt_pkg::CTRL_DMAEN));
		period("down period", 10);
		chk("adc_trig", {31'h0, adc_trig}, 32'h1);
		chk("dma_req", {31'h0, dma_req}, 32'h1);
		wr(gpt_pkg::GPT_CTRL, 32'h1 | (32'h2 << gpt_pkg::CTRL_DIR_LO));
		period("updown period", 8);
		$display("test count done");
	endtask
	task automatic t_freeze;
		wr(gpt_pkg::GPT_CTRL, 32'h1 | (32'h1 << gpt_pkg::CTRL_FRZ));
		dbg_halt <= 1'b1;
		count_trig(40, n);
		chk("frozen", n, 0);
		@(posedge clk) dbg_halt <= 1'b0;
		count_trig(40, n);
		chk("thawed", n, 4);
		wr(gpt_pkg::GPT_CTRL, 32'h1);
		dbg_halt <= 1'b1;
		count_trig(40, n);
		chk("no freeze", n, 4);
		@(posedge clk) dbg_halt <= 1'b0;
		$display("test freeze done");
	endtask
	task automatic t_irq;
		wr(gpt_pkg::GPT_CTRL, 32'h0);
		rd(gpt_pkg::GPT_STAT, rv);
		wr(gpt_pkg::GPT_MASK, 32'h1);
		wr(gpt_pkg::GPT_CTRL, 32'h1);
		sync_trig();
		wr(gpt_pkg::GPT_CTRL, 32'h0);
		chk("irq set", {31'h0, irq}, 32'h1);
		rd(gpt_pkg::GPT_STAT, rv);
		chk("stat upd", {31'h0, rv[gpt_pkg::STAT_UPD]}, 32'h1);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		wr(gpt_pkg::GPT_MASK, 32'h0);
		wr(gpt_pkg::GPT_CTRL, 32'h1);
		sync_trig();
		wr(gpt_pkg::GPT_CTRL, 32'h1 << gpt_pkg::CTRL_SLAVE);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd(gpt_pkg::GPT_STAT, rv);
		@(posedge clk) sync_in <= 1'b1;
		repeat (3) @(posedge clk);
		rd(gpt_pkg::GPT_STAT, rv);
		chk("sync start", {31'h0, rv[gpt_pkg::STAT_TRG]}, 32'h1);
		@(posedge clk) sync_in <= 1'b0;
		wr(gpt_pkg::GPT_CTRL, 32'h1 << gpt_pkg::CTRL_HALL);
		rd(gpt_pkg::GPT_STAT, rv);
		@(posedge clk) hall <= 1'b1;
		repeat (3) @(posedge clk);
		rd(gpt_pkg::GPT_STAT, rv);
		chk("hall edge", {31'h0, rv[gpt_pkg::STAT_TRG]}, 32'h1);
		@(posedge clk) hall <= 1'b0;
		$display("test irq done");
	endtask
	task automatic t_slow;
		slow_on <= 1'b1;
		wr(gpt_pkg::GPT_PSC, 32'h0);
		wr(gpt_pkg::GPT_ARR, 32'h1);
		wr(gpt_pkg::GPT_CTRL, 32'h1 | (32'h1 << gpt_pkg::CTRL_CLKSEL));
		period("slow clock period", 16);
		slow_on <= 1'b0;
		$display("test slow clock done");
	endtask
	task automatic t_enc;
		wr(gpt_pkg::GPT_ARR, 32'hffff);
		wr(gpt_pkg::GPT_CTRL, 32'h1 | (32'h1 << gpt_pkg::CTRL_ENC));
		rd(gpt_pkg::GPT_CNT, base);
		steps(4, 1'b1);
		rd(gpt_pkg::GPT_CNT, rv);
		chk("enc fwd", rv, (base + 32'h2) & 32'hffff);
		steps(4, 1'b0);
		rd(gpt_pkg::GPT_CNT, rv);
		chk("enc back", rv, base);
		rd(gpt_pkg::GPT_CC0, rv);
		chk("capture", rv, (base + 32'h2) & 32'hffff);
		$display("test encoder done");
	endtask
	task automatic t_pwm;
		int n2, tg;
		logic prev;
		wr(gpt_pkg::GPT_CTRL, 32'h0);
		wr(gpt_pkg::GPT_ARR, 32'h4);
		wr(gpt_pkg::GPT_CC0, 32'h2);
		wr(8'h2c, 32'h3);
		wr(gpt_pkg::GPT_CCMODE, 32'hb6);
		wr(gpt_pkg::GPT_CTRL, 32'h1);
		sync_trig();
		clr <= 1'b0;
		n = 0;
		n2 = 0;
		tg = 0;
		prev = ch_out[1];
		repeat (5) begin
			@(posedge clk);
			#1 n += (ch_out[3] === 1'b1);
			n2 += (ch_out[2] === 1'b1);
			tg += (ch_out[1] !== prev);
			prev = ch_out[1];
		end
		chk("pwm ch0 high", {16'h0, high_cnt}, 32'h2);
		chk("pwm ch3 high", n, 3);
		chk("one pulse ch2 high", n2, 4);
		chk("toggle ch1", tg, 1);
		clr <= 1'b1;
		$display("test pwm done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_count();
		t_freeze();
		t_irq();
		t_slow();
		t_enc();
		t_pwm();
		give_verdict();
	end
	initial begin
		repeat (6000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule // test_gpt_timer
